// *** design/packet_sync_length_address_filter.sv ***
// Packet framer: marker search, length handling, address filter and trailer.
// Assumes the SPI decoder presents one-cycle register strobes and that the
// demodulator supplies bits, signal strength, link quality and check results.
`include "pkt_filter_cfg.svh"

module packet_sync_length_address_filter
   import pkt_filter_pkg::*;
#(
   parameter int QUALITY_W = 6
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register port from the SPI decoder.
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Received bit stream and packet status from the demodulator.
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_stop,
   input wire logic check_valid,
   input wire logic check_ok,
   input wire logic [7:0] signal_strength_reading,
   input wire logic [6:0] link_quality_reading,
   // Toward the RX FIFO.
   output pkt_filter_pkg::byte_type rx_byte,
   output logic rx_flush,
   output logic packet_drop,
   output logic marker_found,
   // Toward the transmitter.
   output logic [15:0] tx_marker,
   output logic [7:0] tx_packet_length,
   output logic [1:0] tx_size_mode
);
   import pkt_filter_pkg::*;

   // ********************************************************
   // Register file
   // ********************************************************
   cfg_type cfg_reg;
   logic [7:0] handling_value;
   logic [7:0] automation_value;
   logic [7:0] read_value;

   // Unused bits of the two control registers read as zero.
   assign handling_value = {cfg_reg.quality_thr, 1'b0, cfg_reg.bad_check_discard,
                            cfg_reg.trailer_enable, cfg_reg.dest_filter_mode};
   assign automation_value = {6'h00, cfg_reg.size_mode};
   assign read_value =
      (reg_addr == `OFS_MARKER_HIGH) ? cfg_reg.marker[15:8] :
      (reg_addr == `OFS_MARKER_LOW) ? cfg_reg.marker[7:0] :
      (reg_addr == `OFS_PACKET_SIZE) ? cfg_reg.packet_size :
      (reg_addr == `OFS_PKT_HANDLING) ? handling_value :
      (reg_addr == `OFS_PKT_AUTOMATION) ? automation_value :
      (reg_addr == `OFS_NODE_ADDRESS) ? cfg_reg.node_address : 8'h00;

   // Register writes; offsets outside the map are ignored.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_reg.marker <= {`RST_MARKER_HIGH, `RST_MARKER_LOW}; // [RULE1] [RULE2]
         cfg_reg.packet_size <= `RST_PACKET_SIZE;
         cfg_reg.quality_thr <= `RST_QUALITY_THR;
         cfg_reg.bad_check_discard <= `RST_BAD_CHECK_DISCARD;
         cfg_reg.trailer_enable <= `RST_TRAILER_ENABLE;
         cfg_reg.dest_filter_mode <= `RST_DEST_FILTER;
         cfg_reg.size_mode <= `RST_SIZE_MODE;
         cfg_reg.node_address <= `RST_NODE_ADDRESS; // [RULE15]
      end
      else if (reg_write)
      begin
         case (reg_addr)
            `OFS_MARKER_HIGH: cfg_reg.marker[15:8] <= reg_wdata; // [RULE1]
            `OFS_MARKER_LOW: cfg_reg.marker[7:0] <= reg_wdata; // [RULE2]
            `OFS_PACKET_SIZE: cfg_reg.packet_size <= reg_wdata;
            `OFS_PKT_HANDLING:
            begin
               cfg_reg.quality_thr <= reg_wdata[`FLD_QUALITY_THR];
               cfg_reg.bad_check_discard <= reg_wdata[`FLD_BAD_CHECK_DISCARD];
               cfg_reg.trailer_enable <= reg_wdata[`FLD_TRAILER_ENABLE];
               cfg_reg.dest_filter_mode <= reg_wdata[`FLD_DEST_FILTER];
            end
            `OFS_PKT_AUTOMATION: cfg_reg.size_mode <= reg_wdata[`FLD_SIZE_MODE];
            `OFS_NODE_ADDRESS: cfg_reg.node_address <= reg_wdata;
            default: cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Read data is captured on the read strobe and held until the next one.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_read)
         reg_rdata <= read_value;
   end

   // ********************************************************
   // Transmit configuration
   // ********************************************************
   // The transmitter takes the same size register and marker as the receiver.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_marker <= {`RST_MARKER_HIGH, `RST_MARKER_LOW};
         tx_packet_length <= `RST_PACKET_SIZE;
         tx_size_mode <= `RST_SIZE_MODE;
      end
      else
      begin
         tx_marker <= cfg_reg.marker;
         tx_packet_length <= cfg_reg.packet_size; // [RULE3]
         tx_size_mode <= cfg_reg.size_mode;
      end
   end

   // ********************************************************
   // Receive datapath
   // ********************************************************
   rx_state_type state_reg;
   rx_state_type state_next;
   logic [15:0] shift_reg;
   logic [2:0] bit_count_reg;
   logic [7:0] bytes_left_reg;
   logic quality_ok;
   logic [15:0] shift_next;
   logic byte_done;
   logic marker_hit;
   logic [7:0] byte_value;
   logic address_pass;
   logic length_bad;
   logic last_byte;
   logic check_ok_reg;

   preamble_quality #(
      .COUNT_W(QUALITY_W)
   ) quality_unit (
      .clock(clock),
      .rst_n(rst_n),
      .bit_valid(rx_bit_valid),
      .bit_value(rx_bit),
      .quality_thr(cfg_reg.quality_thr),
      .quality_ok(quality_ok)
   );

   // Address filter decode, shared by every filter code.
   function automatic logic filter_accepts(input logic [1:0] mode, input logic [7:0] dest,
                                           input logic [7:0] own);
      logic own_hit;
      own_hit = (dest == own);
      case (mode)
         `FILTER_NONE: filter_accepts = 1'b1; // [RULE12]
         `FILTER_OWN: filter_accepts = own_hit; // [RULE12]
         `FILTER_OWN_ZERO: filter_accepts = own_hit || (dest == `BROADCAST_ZERO); // [RULE13]
         default: filter_accepts = own_hit || (dest == `BROADCAST_ZERO)
                                   || (dest == `BROADCAST_ONES); // [RULE14]
      endcase
   endfunction : filter_accepts

   // Bytes are assembled first bit most significant.
   assign shift_next = {shift_reg[14:0], rx_bit};
   assign byte_value = shift_next[7:0];
   assign byte_done = rx_bit_valid && (bit_count_reg == `BIT_COUNT_LAST);
   assign marker_hit = rx_bit_valid && (shift_next == cfg_reg.marker) && quality_ok; // [RULE7]
   assign address_pass = filter_accepts(cfg_reg.dest_filter_mode, byte_value,
                                        cfg_reg.node_address); // [RULE19]
   assign length_bad = (byte_value > cfg_reg.packet_size); // [RULE4] [RULE18]
   assign last_byte = (bytes_left_reg == 8'h01)
                      && (cfg_reg.size_mode != `SIZE_UNBOUNDED); // [RULE17]

   // Next state of the receive sequence.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HUNT:
            if (marker_hit)
               state_next = (cfg_reg.size_mode == `SIZE_VARIABLE) ? ST_LENGTH // [RULE17]
                  : (cfg_reg.dest_filter_mode != `FILTER_NONE) ? ST_ADDRESS : ST_PAYLOAD;
         ST_LENGTH:
            if (byte_done)
               state_next = length_bad ? ST_HUNT // [RULE18]
                  : (byte_value == 8'h00) ? ST_WAIT_CHECK
                  : (cfg_reg.dest_filter_mode != `FILTER_NONE) ? ST_ADDRESS : ST_PAYLOAD;
         ST_ADDRESS:
            if (byte_done)
               state_next = !address_pass ? ST_HUNT : last_byte ? ST_WAIT_CHECK : ST_PAYLOAD;
         ST_PAYLOAD:
            if (byte_done && last_byte)
               state_next = ST_WAIT_CHECK;
         ST_WAIT_CHECK:
            if (check_valid)
               state_next = (!check_ok && cfg_reg.bad_check_discard) ? ST_HUNT
                  : cfg_reg.trailer_enable ? ST_TRAILER_1 : ST_HUNT; // [RULE11]
         ST_TRAILER_1: state_next = ST_TRAILER_2;
         ST_TRAILER_2: state_next = ST_HUNT;
         default: state_next = ST_HUNT;
      endcase
      // An aborted reception ends the packet in any state except the two trailer states; unbounded mode relies on it.
      if (rx_stop && (state_reg != ST_TRAILER_1) && (state_reg != ST_TRAILER_2))
         state_next = ST_HUNT;
   end

   // State, bit assembly and remaining byte count.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_HUNT;
         shift_reg <= 16'h0000;
         bit_count_reg <= 3'h0;
         bytes_left_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (rx_bit_valid)
            shift_reg <= shift_next;
         if ((state_reg == ST_HUNT) || !rx_bit_valid)
            bit_count_reg <= 3'h0;
         else
            bit_count_reg <= bit_count_reg + 3'h1;
         if (state_reg == ST_HUNT)
            bytes_left_reg <= cfg_reg.packet_size; // [RULE3] [RULE16]
         else if ((state_reg == ST_LENGTH) && byte_done)
            bytes_left_reg <= byte_value; // [RULE17]
         else if (byte_done)
            bytes_left_reg <= bytes_left_reg - 8'h01;
      end
   end

   // Output strobes toward the RX FIFO, all registered.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_byte <= '0;
         rx_flush <= 1'b0;
         packet_drop <= 1'b0;
         marker_found <= 1'b0;
      end
      else
      begin
         rx_byte.valid <= 1'b0;
         rx_flush <= 1'b0;
         packet_drop <= 1'b0;
         marker_found <= (state_reg == ST_HUNT) && marker_hit; // [RULE8]
         case (state_reg)
            ST_LENGTH, ST_ADDRESS, ST_PAYLOAD:
               if (byte_done)
               begin
                  rx_byte.valid <= 1'b1;
                  rx_byte.data <= byte_value;
                  if (((state_reg == ST_LENGTH) && length_bad)
                      || ((state_reg == ST_ADDRESS) && !address_pass))
                  begin
                     rx_byte.valid <= 1'b0;
                     rx_flush <= 1'b1; // [RULE18] [RULE19]
                     packet_drop <= 1'b1;
                  end
               end
            ST_WAIT_CHECK:
               if (check_valid && !check_ok && cfg_reg.bad_check_discard)
               begin
                  rx_flush <= 1'b1; // [RULE9]
                  packet_drop <= 1'b1;
               end
            ST_TRAILER_1:
            begin
               rx_byte.valid <= 1'b1;
               rx_byte.data <= signal_strength_reading; // [RULE11]
            end
            ST_TRAILER_2:
            begin
               rx_byte.valid <= 1'b1;
               rx_byte.data <= {check_ok_reg, link_quality_reading}; // [RULE11]
            end
            default: rx_byte.data <= rx_byte.data;
         endcase
      end
   end

   // The check result is held so the trailer carries it after check_valid falls.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         check_ok_reg <= 1'b0;
      else if ((state_reg == ST_WAIT_CHECK) && check_valid)
         check_ok_reg <= check_ok;
   end

endmodule : packet_sync_length_address_filter

// *** design/pkt_filter_cfg.svh ***
// Constants of the packet framer: register offsets, reset values, field positions.
// Assumes it is included once by bare name from each design file that needs it.
//
// Contract
// RULE1: Marker high byte register, resets to d3.
// RULE2: Marker low byte register, resets to 91.
// RULE3: Fixed mode: size register is exact length.
// RULE4: Variable mode: size register is maximum length.
// RULE5: Quality counter adds one on bit change.
// RULE6: Quality counter subtracts eight on repeated bit.
// RULE7: Marker detection needs counter at four times threshold.
// RULE8: Threshold zero accepts any detected marker.
// RULE9: Discard bit flushes RX FIFO on check failure.
// RULE10: Host keeps one packet, length within FIFO.
// RULE11: Trailer bit appends strength and quality bytes.
// RULE12: Filter 00 none; 01 own address only.
// RULE13: Filter 10 accepts own address or 00.
// RULE14: Filter 11 accepts own, 00 or ff.
// RULE15: Own node address register, resets to zero.
// RULE16: Size mode 00 selects fixed length.
// RULE17: Mode 01 length byte; 10 unbounded length.
// RULE18: Variable length above maximum discards the packet.
// RULE19: First byte after length is destination address.
`ifndef PKT_FILTER_CFG_SVH
`define PKT_FILTER_CFG_SVH

// ********************************************************
// Register offsets
// ********************************************************
`define OFS_MARKER_HIGH 6'h04
`define OFS_MARKER_LOW 6'h05
`define OFS_PACKET_SIZE 6'h06
`define OFS_PKT_HANDLING 6'h07
`define OFS_PKT_AUTOMATION 6'h08
`define OFS_NODE_ADDRESS 6'h09

// ********************************************************
// Reset values
// ********************************************************
`define RST_MARKER_HIGH 8'hd3
`define RST_MARKER_LOW 8'h91
`define RST_PACKET_SIZE 8'hff
`define RST_QUALITY_THR 3'h0
`define RST_BAD_CHECK_DISCARD 1'h0
`define RST_TRAILER_ENABLE 1'h1
`define RST_DEST_FILTER 2'h0
`define RST_SIZE_MODE 2'h1
`define RST_NODE_ADDRESS 8'h00

// ********************************************************
// Field positions in the control registers
// ********************************************************
`define FLD_QUALITY_THR 7:5
`define FLD_BAD_CHECK_DISCARD 3
`define FLD_TRAILER_ENABLE 2
`define FLD_DEST_FILTER 1:0
`define FLD_SIZE_MODE 1:0

// ********************************************************
// Codes and constants
// ********************************************************
`define FILTER_NONE 2'h0
`define FILTER_OWN 2'h1
`define FILTER_OWN_ZERO 2'h2
`define FILTER_OWN_BOTH 2'h3
`define SIZE_FIXED 2'h0
`define SIZE_VARIABLE 2'h1
`define SIZE_UNBOUNDED 2'h2
`define BROADCAST_ZERO 8'h00
`define BROADCAST_ONES 8'hff
`define QUALITY_STEP_UP 1
`define QUALITY_STEP_DOWN 8
`define QUALITY_THR_SCALE 4
`define BIT_COUNT_LAST 3'h7

`endif

// *** design/pkt_filter_pkg.sv ***
// Types shared by the packet framer, its checker and the testbench.
// Assumes the constants header is compiled alongside.
package pkt_filter_pkg;

   // Configuration fields that steer the receive and transmit paths.
   typedef struct packed {
      logic [15:0] marker;
      logic [7:0] packet_size;
      logic [2:0] quality_thr;
      logic bad_check_discard;
      logic trailer_enable;
      logic [1:0] dest_filter_mode;
      logic [1:0] size_mode;
      logic [7:0] node_address;
   } cfg_type;

   // One byte toward the RX FIFO.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } byte_type;

   // Receive state machine.
   typedef enum logic [2:0] {
      ST_HUNT = 3'b000,
      ST_LENGTH = 3'b001,
      ST_ADDRESS = 3'b010,
      ST_PAYLOAD = 3'b011,
      ST_WAIT_CHECK = 3'b100,
      ST_TRAILER_1 = 3'b101,
      ST_TRAILER_2 = 3'b110
   } rx_state_type;

endpackage : pkt_filter_pkg

// *** design/preamble_quality.sv ***
// Preamble quality estimator: counts bit transitions on the received stream.
// Assumes one bit per cycle at most, flagged by bit_valid.
`include "pkt_filter_cfg.svh"

module preamble_quality #(
   parameter int COUNT_W = 6
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Received bits.
   input wire logic bit_valid,
   input wire logic bit_value,
   // Threshold field and the gate it produces.
   input wire logic [2:0] quality_thr,
   output logic quality_ok
);
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic prev_reg;
   logic [COUNT_W-1:0] count_max;
   logic [COUNT_W:0] threshold;

   // The counter saturates at both ends so noise cannot wrap it into a false pass.
   assign count_max = '1;
   assign count_next = (bit_value != prev_reg)
      ? ((count_reg == count_max) ? count_reg
         : count_reg + COUNT_W'(`QUALITY_STEP_UP)) // [RULE5]
      : ((count_reg < COUNT_W'(`QUALITY_STEP_DOWN)) ? '0
         : count_reg - COUNT_W'(`QUALITY_STEP_DOWN)); // [RULE6]
   assign threshold = (COUNT_W+1)'(quality_thr) * (COUNT_W+1)'(`QUALITY_THR_SCALE);
   assign quality_ok = (quality_thr == 3'h0) // [RULE8]
      || ({1'b0, count_reg} >= threshold); // [RULE7]

   // Counter and previous bit update on each received bit.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= '0;
         prev_reg <= 1'b0;
      end
      else if (bit_valid)
      begin
         count_reg <= count_next;
         prev_reg <= bit_value;
      end
   end

endmodule : preamble_quality

// *** sim/pkt_filter_checker.sv ***
// Port-level assertions for the packet framer.
// Assumes it is bound to the framer top module and sees only its ports.
module pkt_filter_checker
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register port.
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Stream status and outputs.
   input wire logic check_valid,
   input wire logic check_ok,
   input wire pkt_filter_pkg::byte_type rx_byte,
   input wire logic rx_flush,
   input wire logic packet_drop,
   input wire logic marker_found,
   input wire logic [15:0] tx_marker,
   input wire logic [7:0] tx_packet_length,
   input wire logic [1:0] tx_size_mode
);
   import pkt_filter_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ********************************************************
   // Sequences
   // ********************************************************
   sequence wr_high_s;
      reg_write && reg_addr == 6'h04;
   endsequence
   sequence wr_low_s;
      reg_write && reg_addr == 6'h05;
   endsequence
   sequence wr_size_s;
      reg_write && reg_addr == 6'h06;
   endsequence
   // A check result followed by the second trailer byte.
   sequence trailer_s;
      check_valid ##3 rx_byte.valid;
   endsequence
   // ********************************************************
   // Assertions
   // ********************************************************
   // Config copies lag the register by one cycle, so a write shows two edges on.
   rst_copy_a: assert property ($rose(rst_n) |-> tx_marker == 16'hd391)
      else $error("marker copy not at reset value");
   high_copy_a: assert property (wr_high_s |-> ##2 tx_marker[15:8] == $past(reg_wdata, 2))
      else $error("marker high copy wrong");
   low_copy_a: assert property (wr_low_s |-> ##2 tx_marker[7:0] == $past(reg_wdata, 2))
      else $error("marker low copy wrong");
   size_copy_a: assert property (wr_size_s |-> ##2 tx_packet_length == $past(reg_wdata, 2))
      else $error("packet size copy wrong");
   // Read data must agree with what the framer is actually using.
   high_read_a: assert property (reg_read && reg_addr == 6'h04 |=> reg_rdata == tx_marker[15:8])
      else $error("marker high read differs");
   size_read_a: assert property (reg_read && reg_addr == 6'h06 |=> reg_rdata == tx_packet_length)
      else $error("packet size read differs");
   mode_read_a: assert property (reg_read && reg_addr == 6'h08 |=> reg_rdata == {6'h00, tx_size_mode})
      else $error("size mode read differs");
   flush_pair_a: assert property (rx_flush |-> packet_drop)
      else $error("flush without drop");
   drop_nobyte_a: assert property (packet_drop |-> !rx_byte.valid)
      else $error("byte written on drop");
   trailer_ok_a: assert property (trailer_s |-> rx_byte.data[7] == $past(check_ok, 3))
      else $error("trailer check flag wrong");
   // The first byte needs eight more bits after the marker.
   marker_gap_a: assert property (marker_found |=> !rx_byte.valid [*7])
      else $error("byte too soon after marker");
endmodule : pkt_filter_checker

bind packet_sync_length_address_filter pkt_filter_checker chk (
   .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .check_valid(check_valid), .check_ok(check_ok), .rx_byte(rx_byte),
   .rx_flush(rx_flush), .packet_drop(packet_drop), .marker_found(marker_found),
   .tx_marker(tx_marker), .tx_packet_length(tx_packet_length), .tx_size_mode(tx_size_mode)
);

// *** sim/remote_sender.sv ***
// Model of the remote transmitter that feeds demodulated bits to the framer.
// Assumes the caller keeps the framer clock running.
module remote_sender
(
   // Clock.
   input wire logic clock,
   // Bit stream.
   output logic rx_bit_valid,
   output logic rx_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rx_bit_valid = 1'b0;
      rx_bit = 1'b0;
   end
   // Sends a byte most significant bit first with no gaps, since a gap resets the bit count.
   task send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clock);
         rx_bit_valid <= 1'b1;
         rx_bit <= b[i];
      end
   endtask : send
   // Ends a frame; the line flips so a stale bit is never mistaken for data.
   task idle();
      @(posedge clock);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~rx_bit;
   endtask : idle
endmodule : remote_sender

// *** sim/testbench.sv ***
// Self-checking bench for the packet framer.
// Assumes the framer, its package and the bit sender model are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pkt_filter_pkg::*;
   logic clock, rst_n, reg_write, reg_read, check_valid, check_ok, ok, stop;
   logic rx_bit_valid, rx_bit, rx_flush, packet_drop, marker_found;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, strength, own, pl, d;
   logic [6:0] quality;
   byte_type rx_byte;
   int bad_count, comparisons, drops, flushes, markers, seed;
   logic [7:0] tx[$], got[$], exp[$], dst[4];
   logic [5:0] ofs[7] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h3f};
   logic [7:0] rv[7] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h01, 8'h00, 8'h00};
   logic [7:0] msk[7] = '{8'hff, 8'hff, 8'hff, 8'hef, 8'h03, 8'hff, 8'h00};

   // Framer and the remote bit source.
   packet_sync_length_address_filter dut (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit), .rx_stop(stop), .check_valid(check_valid), .check_ok(check_ok),
      .signal_strength_reading(strength), .link_quality_reading(quality),
      .rx_byte(rx_byte), .rx_flush(rx_flush), .packet_drop(packet_drop),
      .marker_found(marker_found), .tx_marker(), .tx_packet_length(), .tx_size_mode());
   remote_sender sender (.clock(clock), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

   // 40 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Collects bytes and pulses with pre-edge values, so there is no race with the framer.
   always @(posedge clock)
   begin
      if (rx_byte.valid === 1'b1)
         got.push_back(rx_byte.data);
      drops += int'(packet_drop === 1'b1);
      flushes += int'(rx_flush === 1'b1);
      markers += int'(marker_found === 1'b1);
   end

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #400000;
      bad_count++;
      results();
   end

   task check(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check

   task results();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   task wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr

   // Read data is taken one edge after the strobe and then holds.
   task rd_chk(input logic [5:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      check(reg_rdata, e);
   endtask : rd_chk

   // Acceptance expected from the destination filter code.
   function automatic bit filt_ok(input logic [1:0] m, input logic [7:0] a, input logic [7:0] o);
      return m == 2'h0 || a == o || (m[1] && a == 8'h00) || (m == 2'h3 && a == 8'hff);
   endfunction : filt_ok

   // Sends preamble, marker and tx bytes, optionally a check result, then compares.
   task pkt(input int pre, input logic [7:0] pb, input logic res, input bit do_check);
      got.delete();
      drops = 0;
      flushes = 0;
      markers = 0;
      repeat (pre) sender.send(pb);
      sender.send(8'hd3);
      sender.send(8'h91);
      foreach (tx[i]) sender.send(tx[i]);
      sender.idle();
      repeat (12) @(posedge clock);
      if (do_check)
      begin
         check_valid <= 1'b1;
         check_ok <= res;
         @(posedge clock);
         check_valid <= 1'b0;
         repeat (8) @(posedge clock);
      end
      check(8'(got.size()), 8'(exp.size()));
      foreach (exp[i])
         if (i < got.size())
            check(got[i], exp[i]);
   endtask : pkt

   // Main sequence.
   initial
   begin
      seed = 32'haeb3;
      rst_n = 1'b0;
      {reg_addr, reg_wdata, reg_write, reg_read, check_valid, check_ok, stop} = '0;
      strength = 8'h00;
      quality = 7'h00;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      foreach (ofs[i]) rd_chk(ofs[i], rv[i]);
      repeat (4)
         foreach (ofs[i])
         begin
            d = 8'($random(seed));
            wr(ofs[i], d);
            rd_chk(ofs[i], d & msk[i]);
         end
      // The random writes moved the marker; put back the pattern the sender uses.
      wr(6'h04, 8'hd3);
      wr(6'h05, 8'h91);
      // Fixed length three with every filter code and every kind of destination.
      own = {1'b0, 6'($random(seed)), 1'b1};
      dst = '{own, 8'h00, 8'hff, own ^ 8'h02};
      wr(6'h09, own);
      wr(6'h08, 8'h00);
      wr(6'h06, 8'h03);
      for (int m = 0; m < 4; m++)
         foreach (dst[j])
         begin
            strength <= 8'($random(seed));
            quality <= 7'($random(seed));
            ok = 1'($random(seed));
            pl = 8'($random(seed));
            wr(6'h07, {6'h01, 2'(m)});
            tx = '{dst[j], pl, ~pl};
            exp.delete();
            if (filt_ok(2'(m), dst[j], own))
               exp = '{dst[j], pl, ~pl, strength, {ok, quality}};
            pkt(0, 8'h00, ok, filt_ok(2'(m), dst[j], own));
            check(8'(drops), 8'(!filt_ok(2'(m), dst[j], own)));
            check(8'(markers), 8'h01);
         end
      // Variable length at the maximum and one above it.
      wr(6'h07, 8'h04);
      wr(6'h08, 8'h01);
      wr(6'h06, 8'h04);
      for (int n = 4; n < 6; n++)
      begin
         pl = 8'($random(seed));
         tx = '{8'(n)};
         repeat (n) tx.push_back(pl);
         exp = tx;
         exp.push_back(strength);
         exp.push_back({1'b1, quality});
         if (n == 5)
            exp.delete();
         pkt(0, 8'h00, 1'b1, n == 4);
         check(8'(drops), 8'(n == 5));
      end
      // Discard on failed check, trailer off; packets stay within one FIFO load.
      wr(6'h07, 8'h08);
      wr(6'h08, 8'h00);
      wr(6'h06, 8'h02);
      for (int k = 0; k < 2; k++)
      begin
         pl = 8'($random(seed));
         tx = '{pl, ~pl};
         exp = tx;
         pkt(0, 8'h00, 1'(k), 1'b1);
         check(8'(flushes), 8'(k == 0));
      end
      // Unbounded length never ends by count; only the stop pulse returns to marker search.
      wr(6'h08, 8'h02);
      exp = tx;
      pkt(0, 8'h00, 1'b1, 1'b0);
      check(8'(markers), 8'h01);
      stop <= 1'b1;
      @(posedge clock);
      stop <= 1'b0;
      wr(6'h08, 8'h00);
      // Quality gate: flat bits keep the counter low, a long alternating run lifts it.
      wr(6'h07, 8'h20);
      exp.delete();
      pkt(2, 8'h00, 1'b1, 1'b0);
      check(8'(markers), 8'h00);
      exp = tx;
      pkt(8, 8'haa, 1'b1, 1'b1);
      check(8'(markers), 8'h01);
      results();
   end
endmodule : testbench
